// *** pwmef_defines.vh ***
`ifndef PWMEF_DEFINES_VH
`define PWMEF_DEFINES_VH

// register byte offsets
`define PWMEF_EVENT_FLAGS_OFS 12'h0E8
`define PWMEF_BRAKE_FLAGS_OFS 12'h0EC

// reset values
`define PWMEF_EVENT_FLAGS_RST 32'h00000000
`define PWMEF_BRAKE_FLAGS_RST 32'h00000000

// event flag register field positions
`define PWMEF_DN_CMP_LSB 24
`define PWMEF_UP_CMP_LSB 16
`define PWMEF_PERIOD4_BIT 12
`define PWMEF_PERIOD2_BIT 10
`define PWMEF_PERIOD0_BIT 8
`define PWMEF_ZERO2_BIT 2
`define PWMEF_ZERO0_BIT 0

// brake flag register field positions
`define PWMEF_LVL_BRAKE_LSB 24

// implemented bits of the event flag register
`define PWMEF_EVENT_MASK 32'h3F3F1505

// counter type encodings
`define PWMEF_TYPE_UP 2'h0
`define PWMEF_TYPE_DOWN 2'h1
`define PWMEF_TYPE_UPDOWN 2'h2

// data width of the register bus
`define PWMEF_DATA_W 32

`endif

// *** pwmef_channel.v ***
`include "pwmef_defines.vh"
`default_nettype none

module pwmef_channel #(
    parameter CNT_W = 16
) (
    input wire pclk,
    input wire presetn,
    input wire cnt_tick,
    input wire [CNT_W-1:0] cnt_value,
    input wire cnt_down,
    input wire [1:0] cnt_type,
    input wire [CNT_W-1:0] cmp_value,
    input wire [CNT_W-1:0] per_value,
    input wire clr_up,
    input wire clr_dn,
    input wire brake_hit,
    input wire brake_sources_high,
    input wire period_end,
    output reg up_compare_flag,
    output reg down_compare_flag,
    output reg level_brake_state
);

    wire cmp_hit;
    wire cmp_is_per;
    wire set_up;
    wire set_dn;

    assign cmp_hit = cnt_tick && (cnt_value == cmp_value);
    assign cmp_is_per = (cmp_value == per_value);
    // up flag silent when compare equals period in up type
    assign set_up = cmp_hit && !cnt_down &&
        !(cmp_is_per && cnt_type == `PWMEF_TYPE_UP);
    // down flag silent when compare equals period in down type
    assign set_dn = cmp_hit && cnt_down &&
        !(cmp_is_per && cnt_type == `PWMEF_TYPE_DOWN);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_compare_flag <= 1'b0;
            down_compare_flag <= 1'b0;
            level_brake_state <= 1'b0;
        end else begin
            // set wins over a write-one clear in the same cycle
            if (set_up)
                up_compare_flag <= 1'b1;
            else if (clr_up)
                up_compare_flag <= 1'b0;
            if (set_dn)
                down_compare_flag <= 1'b1;
            else if (clr_dn)
                down_compare_flag <= 1'b0;
            if (brake_hit)
                level_brake_state <= 1'b1;
            else if (brake_sources_high && period_end)
                level_brake_state <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// *** pwmef_top.v ***
`include "pwmef_defines.vh"
`default_nettype none

// Behaviour
// - each channel's down flag sets when counting down hits compare; W1C.
// - down flag inactive when compare equals period in down-count type.
// - complementary mode: odd down flags become second flag of even channel.
// - each channel's up flag sets when counting up hits compare; W1C.
// - up flag inactive when compare equals period in up-count type.
// - complementary mode: odd up flags become extra flag of even channel.
// - channel-4 period flag sets when its counter hits period; W1C.
// - channel-2 period flag sets when its counter hits period; W1C.
// - level brake state sets on falling edge of any enabled source.
// - level brake state bits read-only; only hardware clears them.
// - after sources go high, brake holds until current period ends.
// - in up-down type the period point is the center point.
module pwmef_top #(
    parameter CNT_W = 16,
    parameter ADDR_W = 12,
    parameter NUM_BRK = 2
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    input wire [5:0] cnt_tick,
    input wire [6*CNT_W-1:0] cnt_value,
    input wire [5:0] cnt_down,
    input wire [5:0] cnt_type,
    input wire [6*CNT_W-1:0] channel_compare_value,
    input wire [6*CNT_W-1:0] period_value,
    input wire [2:0] complementary_mode,
    input wire [NUM_BRK-1:0] brake_source,
    input wire [NUM_BRK-1:0] brake_source_enable,
    input wire [31:0] event_irq_enable,
    output wire [5:0] level_brake_state,
    output reg pwm_irq
);

    localparam [31:0] EVENT_MASK = `PWMEF_EVENT_MASK;

    wire acc;
    wire wr_acc;
    wire sel_event;
    wire sel_brake;
    wire mapped;
    wire [31:0] clr_bits;
    wire [31:0] event_flags;
    wire [31:0] brake_flags;
    wire [5:0] up_flag;
    wire [5:0] dn_flag;
    wire [5:0] period_end;
    wire [5:0] hit_period;
    wire [5:0] hit_zero;
    wire brake_fall;
    wire brake_high;
    reg [NUM_BRK-1:0] brake_prev;
    reg period_point_flag_ch0;
    reg period_point_flag_ch2;
    reg period_point_flag_ch4;
    reg zero_point_flag_ch0;
    reg zero_point_flag_ch2;
    reg [31:0] next_prdata;

    // apb slave, zero wait states
    assign acc = psel && penable;
    assign wr_acc = acc && pwrite;
    assign sel_event = (paddr == `PWMEF_EVENT_FLAGS_OFS);
    assign sel_brake = (paddr == `PWMEF_BRAKE_FLAGS_OFS);
    assign mapped = sel_event || sel_brake;
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;

    // write-one clear, byte lanes honoured, reserved bits dropped
    assign clr_bits = (wr_acc && sel_event) ?
        (pwdata & EVENT_MASK & {{8{pstrb[3]}}, {8{pstrb[2]}},
        {8{pstrb[1]}}, {8{pstrb[0]}}}) : 32'h00000000;

    // brake source falling edge and all-high detection
    assign brake_fall =
        |(brake_prev & ~brake_source & brake_source_enable);
    assign brake_high =
        &(brake_source | ~brake_source_enable);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            brake_prev <= {NUM_BRK{1'b1}};
        else
            brake_prev <= brake_source;
    end

    genvar i;
    generate
        for (i = 0; i < 6; i = i + 1) begin : g_ch
            localparam integer SRC = (i % 2 == 1) ? i - 1 : i;
            wire comp;
            wire [CNT_W-1:0] own_cnt;
            wire [CNT_W-1:0] src_cnt;
            wire [CNT_W-1:0] src_per;
            wire [1:0] src_type;
            wire src_tick;
            wire src_down;

            assign comp = (i % 2 == 1) && complementary_mode[i/2];
            assign own_cnt = cnt_value[i*CNT_W +: CNT_W];
            // odd channel follows its even partner in complementary mode
            assign src_cnt = comp ?
                cnt_value[SRC*CNT_W +: CNT_W] : own_cnt;
            assign src_per = comp ? period_value[SRC*CNT_W +: CNT_W] :
                period_value[i*CNT_W +: CNT_W];
            assign src_type = comp ? cnt_type[(SRC/2)*2 +: 2] :
                cnt_type[(i/2)*2 +: 2];
            assign src_tick = comp ? cnt_tick[SRC] : cnt_tick[i];
            assign src_down = comp ? cnt_down[SRC] : cnt_down[i];

            assign hit_period[i] = cnt_tick[i] &&
                (own_cnt == period_value[i*CNT_W +: CNT_W]);
            assign hit_zero[i] = cnt_tick[i] &&
                (own_cnt == {CNT_W{1'b0}});
            // period ends at period in up type, else at zero
            assign period_end[i] =
                (cnt_type[(i/2)*2 +: 2] == `PWMEF_TYPE_UP) ?
                hit_period[i] : hit_zero[i];

            pwmef_channel #(
                .CNT_W(CNT_W)
            ) u_ch (
                .pclk(pclk),
                .presetn(presetn),
                .cnt_tick(src_tick),
                .cnt_value(src_cnt),
                .cnt_down(src_down),
                .cnt_type(src_type),
                .cmp_value(channel_compare_value[i*CNT_W +: CNT_W]),
                .per_value(src_per),
                .clr_up(clr_bits[`PWMEF_UP_CMP_LSB + i]),
                .clr_dn(clr_bits[`PWMEF_DN_CMP_LSB + i]),
                .brake_hit(brake_fall),
                .brake_sources_high(brake_high),
                .period_end(period_end[i]),
                .up_compare_flag(up_flag[i]),
                .down_compare_flag(dn_flag[i]),
                .level_brake_state(level_brake_state[i])
            );
        end
    endgenerate

    // period-point flags of the even channels, zero-point flags of channels 0 and 2
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_point_flag_ch0 <= 1'b0;
            period_point_flag_ch2 <= 1'b0;
            period_point_flag_ch4 <= 1'b0;
            zero_point_flag_ch0 <= 1'b0;
            zero_point_flag_ch2 <= 1'b0;
        end else begin
            if (hit_period[4])
                period_point_flag_ch4 <= 1'b1;
            else if (clr_bits[`PWMEF_PERIOD4_BIT])
                period_point_flag_ch4 <= 1'b0;
            if (hit_period[2])
                period_point_flag_ch2 <= 1'b1;
            else if (clr_bits[`PWMEF_PERIOD2_BIT])
                period_point_flag_ch2 <= 1'b0;
            if (hit_period[0])
                period_point_flag_ch0 <= 1'b1;
            else if (clr_bits[`PWMEF_PERIOD0_BIT])
                period_point_flag_ch0 <= 1'b0;
            if (hit_zero[2])
                zero_point_flag_ch2 <= 1'b1;
            else if (clr_bits[`PWMEF_ZERO2_BIT])
                zero_point_flag_ch2 <= 1'b0;
            if (hit_zero[0])
                zero_point_flag_ch0 <= 1'b1;
            else if (clr_bits[`PWMEF_ZERO0_BIT])
                zero_point_flag_ch0 <= 1'b0;
        end
    end

    // register images, reserved bits zero
    assign event_flags = {2'b00, dn_flag, 2'b00, up_flag, 3'b000,
        period_point_flag_ch4, 1'b0, period_point_flag_ch2, 1'b0,
        period_point_flag_ch0, 5'b00000, zero_point_flag_ch2, 1'b0,
        zero_point_flag_ch0};
    // no write path reaches the brake image
    assign brake_flags = {2'b00, level_brake_state,
        24'h000000};

    // read data captured in the setup cycle
    always @* begin
        next_prdata = prdata;
        if (psel && !penable && !pwrite) begin
            if (sel_event)
                next_prdata = event_flags;
            else if (sel_brake)
                next_prdata = brake_flags;
            else
                next_prdata = 32'h00000000;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pwm_irq <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pwm_irq <= |(event_flags & event_irq_enable);
        end
    end

endmodule

`default_nettype wire

// *** pwmef_chk.sv ***
`include "pwmef_defines.vh"
`default_nettype none
module pwmef_chk #(parameter int CNT_W = 16, parameter int ADDR_W = 12,
    parameter int NUM_BRK = 2) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic [5:0] cnt_tick,
    input wire logic [6*CNT_W-1:0] cnt_value,
    input wire logic [5:0] cnt_down,
    input wire logic [6*CNT_W-1:0] channel_compare_value,
    input wire logic [6*CNT_W-1:0] period_value,
    input wire logic [NUM_BRK-1:0] brake_source,
    input wire logic [NUM_BRK-1:0] brake_source_enable,
    input wire logic [31:0] event_irq_enable,
    input wire logic [5:0] level_brake_state,
    input wire logic pwm_irq
);
localparam logic [ADDR_W-1:0] EV = `PWMEF_EVENT_FLAGS_OFS;
localparam logic [ADDR_W-1:0] BK = `PWMEF_BRAKE_FLAGS_OFS;
wire acc = psel && penable;
// channel 0 counter meets a compare value that differs from period
wire hit0 = cnt_tick[0] &&
    cnt_value[CNT_W-1:0] == channel_compare_value[CNT_W-1:0] &&
    channel_compare_value[CNT_W-1:0] != period_value[CNT_W-1:0];
// channel 0 may leave brake: sources high at a period end
wire rel0 = cnt_tick[0] && &(brake_source | ~brake_source_enable) &&
    (cnt_value[CNT_W-1:0] == '0 ||
    cnt_value[CNT_W-1:0] == period_value[CNT_W-1:0]);
default clocking cb @(posedge pclk);
endclocking
default disable iff (!presetn);
AST_DN_SET: assert property ((hit0 && cnt_down[0] ##1
    event_irq_enable[24]) |=> pwm_irq) else $error("down flag missed");
AST_UP_SET: assert property ((hit0 && !cnt_down[0] ##1
    event_irq_enable[16]) |=> pwm_irq) else $error("up flag missed");
AST_IRQ_OFF: assert property ($past(event_irq_enable) == 32'h0
    |-> !pwm_irq) else $error("irq without enable");
AST_BRK_SET: assert property (
    |($past(brake_source) & ~brake_source & brake_source_enable)
    |=> level_brake_state == 6'h3F) else $error("brake not set");
AST_BRK_HOLD: assert property ($fell(level_brake_state[0]) |->
    $past(rel0)) else $error("brake released early");
AST_BRK_RD: assert property (acc && !pwrite && paddr == BK
    |-> prdata[29:24] == $past(level_brake_state))
    else $error("brake read wrong");
AST_RSV: assert property (acc && !pwrite |-> prdata[31:30] == 2'h0 &&
    (paddr != EV || (prdata & ~`PWMEF_EVENT_MASK) == 32'h0))
    else $error("reserved bits not zero");
AST_SLVERR: assert property (acc |->
    pslverr == (paddr != EV && paddr != BK)) else $error("slverr wrong");
endmodule
bind pwmef_top pwmef_chk #(.CNT_W(CNT_W), .ADDR_W(ADDR_W), .NUM_BRK(NUM_BRK))
    u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
    .pslverr, .cnt_tick, .cnt_value, .cnt_down, .channel_compare_value,
    .period_value, .brake_source, .brake_source_enable, .event_irq_enable,
    .level_brake_state, .pwm_irq);
`default_nettype wire

// *** test_pwm_event_flag_logic.sv ***
`include "pwmef_defines.vh"
`default_nettype none
module test_pwm_event_flag_logic;
timeunit 1ns;
timeprecision 1ps;
localparam logic [11:0] EV = `PWMEF_EVENT_FLAGS_OFS;
localparam logic [11:0] BK = `PWMEF_BRAKE_FLAGS_OFS;
logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pwm_irq, rerr;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, event_irq_enable, rdat;
logic [3:0] pstrb;
logic [5:0] cnt_tick, cnt_down, cnt_type, level_brake_state;
logic [95:0] cnt_value, channel_compare_value, period_value;
logic [2:0] complementary_mode;
logic [1:0] brake_source, brake_source_enable;
logic [15:0] cv;
int error_cnt = 0;
int num_checks = 0;
int seed = 32'h621f;
pwmef_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .pready, .prdata, .pslverr, .cnt_tick, .cnt_value, .cnt_down,
    .cnt_type, .channel_compare_value, .period_value, .complementary_mode,
    .brake_source, .brake_source_enable, .event_irq_enable,
    .level_brake_state, .pwm_irq);
initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
end
task complete_run;
    if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
endtask
task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
        $display("BAD %s exp %h got %h", nm, exp, got);
        error_cnt++;
    end
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
        @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
endtask
task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(0, a, 0);
    chk("prdata", exp, rdat);
endtask
task tick(input int ch, input logic [15:0] v, input logic dn);
    @(posedge pclk);
    cnt_value[ch*16+:16] <= v;
    cnt_down[ch] <= dn;
    cnt_tick[ch] <= 1;
    @(posedge pclk);
    cnt_tick <= 0;
endtask
function automatic logic [31:0] fbit(input int base, input int ch);
    return 32'h1 << (base + ch);
endfunction
initial begin
    #20us;
    error_cnt++;
    complete_run();
end
initial begin
    presetn = 0;
    {psel, penable, pwrite, paddr, pwdata, cnt_tick, cnt_value, cnt_down,
        complementary_mode, event_irq_enable} = '0;
    pstrb = 4'hF;
    cnt_type = 6'h2A;
    brake_source = 2'h3;
    brake_source_enable = 2'h1;
    channel_compare_value = '0;
    period_value = {6{16'h8000}};
    repeat (5) @(posedge pclk);
    presetn <= 1;
    rd(EV, 32'h0);
    rd(BK, 32'h0);
    apb(0, 12'h0F0, 0);
    chk("pslverr", 1, rerr);
    apb(1, EV, 32'hFFFFFFFF);
    rd(EV, 32'h0);
    // compare flags may raise the irq, so its assertions get exercised
    event_irq_enable <= 32'h3F3F0000;
    for (int ch = 0; ch < 6; ch++) begin
        // kept clear of zero and of the period value
        cv = 16'h1000 + {4'h0, 12'($random(seed))};
        channel_compare_value[ch*16+:16] <= cv;
        tick(ch, cv + 16'h1, 0);
        tick(ch, cv, 0);
        tick(ch, cv, 1);
        rd(EV, fbit(16, ch) | fbit(24, ch));
        apb(1, EV, fbit(16, ch));
        rd(EV, fbit(24, ch));
        apb(1, EV, fbit(24, ch));
    end
    // compare equal to period in matching single-direction type
    channel_compare_value[16+:16] <= 16'h8000;
    cnt_type <= 6'h28;
    tick(1, 16'h8000, 0);
    cnt_type <= 6'h29;
    tick(1, 16'h8000, 1);
    rd(EV, 32'h0);
    cnt_type <= 6'h2A;
    complementary_mode <= 3'h1;
    channel_compare_value[31:0] <= {16'h1234, 16'h4321};
    tick(0, 16'h1234, 0);
    tick(0, 16'h1234, 1);
    rd(EV, fbit(16, 1) | fbit(24, 1));
    apb(1, EV, 32'hFFFFFFFF);
    complementary_mode <= 3'h0;
    tick(2, 16'h8000, 0);
    tick(4, 16'h8000, 0);
    rd(EV, fbit(10, 0) | fbit(12, 0));
    event_irq_enable <= fbit(12, 0);
    repeat (2) @(negedge pclk);
    chk("pwm_irq", 1, pwm_irq);
    apb(1, EV, fbit(10, 0) | fbit(12, 0));
    repeat (2) @(negedge pclk);
    chk("pwm_irq", 0, pwm_irq);
    @(posedge pclk);
    brake_source <= 2'h1;
    repeat (2) @(negedge pclk);
    chk("brake", 0, level_brake_state);
    @(posedge pclk);
    brake_source <= 2'h2;
    rd(BK, 32'h3F000000);
    apb(1, BK, 32'hFFFFFFFF);
    rd(BK, 32'h3F000000);
    tick(0, 16'h0, 1);
    brake_source <= 2'h3;
    tick(0, 16'h5, 0);
    @(negedge pclk);
    chk("brake", 1, level_brake_state[0]);
    tick(0, 16'h0, 1);
    @(negedge pclk);
    chk("brake", 0, level_brake_state[0]);
    complete_run();
end
endmodule
`default_nettype wire
